//--- design/pvm_cfg.svh
// offsets, field positions, reset values and frame layout constants
`ifndef PVM_CFG_SVH
`define PVM_CFG_SVH
`define PVM_OFS_ADDR_LO 12'h028
`define PVM_OFS_ADDR_HI 12'h02C
`define PVM_OFS_FTYPE 12'h030
`define PVM_OFS_VTYPE 12'h038
`define PVM_OFS_TIMER 12'h170
`define PVM_FIELD_MSB 15
`define PVM_RST_WORD 16'h0000
`define PVM_RST_LOW 32'h0000_0000
`define PVM_SLOT_BYTES 64
`define PVM_PAUSE_OPCODE 16'h0001
`define PVM_IDX_DA_LAST 4'h5
`define PVM_IDX_TYPE_HI 4'hC
`define PVM_IDX_TYPE_LO 4'hD
`define PVM_IDX_RX_DONE 4'hE
`define PVM_TX_TYPE_HI 4'h6
`define PVM_TX_TYPE_LO 4'h7
`define PVM_TX_OP_HI 4'h8
`define PVM_TX_OP_LO 4'h9
`define PVM_TX_TIME_HI 4'hA
`define PVM_TX_PAUSE_LAST 4'hB
`define PVM_TX_VLAN_LAST 4'h1
`endif

//--- design/pvm_field_match.sv
// running byte comparator over one field window of a received frame
`timescale 1ns/100ps
module pvm_field_match
	import pvm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic en,
	input wire logic start,
	input wire logic [7:0] exp_byte,
	input wire logic [7:0] got_byte,
	output logic match_q
);
	logic match_d;

	always_comb begin
		match_d = match_q;
		if (en) begin
			match_d = (start | match_q) & (exp_byte == got_byte);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match_d;
		end
	end
endmodule

//--- design/pvm_pkg.sv
// types shared by the pause and vlan match block
package pvm_pkg;
	typedef struct packed {
		logic valid;
		logic sof;
		logic [7:0] data;
	} pvm_byte_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic wide;
		logic [11:0] addr;
		logic [63:0] wdata;
	} pvm_req_t;

	typedef enum logic [2:0] {
		PVM_IDLE = 3'b001,
		PVM_PAUSE = 3'b010,
		PVM_VLAN = 3'b100
	} pvm_tx_st_t;
endpackage

//--- design/pvm_top.sv
// pause / vlan configuration registers, receive matcher, header sender
`timescale 1ns/100ps
`include "pvm_cfg.svh"
module pvm_top
	import pvm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire pvm_req_t req,
	output logic [63:0] reg_rdata_q,
	output logic reg_rvalid_q,
	input wire pvm_byte_t rx,
	output logic rx_pause_hit,
	output logic rx_vlan_hit,
	input wire logic tx_pause_start,
	input wire logic tx_vlan_start,
	input wire logic tx_ready,
	output logic tx_valid_q,
	output logic [7:0] tx_byte_q,
	output logic [3:0] tx_idx_q,
	output logic tx_busy
);
	////////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] addr_lo_q, addr_lo_d;
	logic [15:0] addr_hi_q, addr_hi_d;
	logic [15:0] ftype_q, ftype_d;
	logic [15:0] vtype_q, vtype_d;
	logic [15:0] timer_q, timer_d;
	logic [63:0] reg_rdata_d;
	logic [47:0] pause_addr;

	assign pause_addr = {addr_hi_q, addr_lo_q};

	function automatic logic [31:0] pad16(input logic [15:0] v);
		pad16 = {16'h0000, v};
	endfunction

	function automatic logic [7:0] addr_byte(input logic [47:0] a,
		input logic [3:0] i);
		addr_byte = a[{i[2:0], 3'b000} +: 8];
	endfunction

	function automatic logic [7:0] type_byte(input logic [15:0] t,
		input logic lo);
		type_byte = lo ? t[7:0] : t[15:8];
	endfunction

	always_comb begin
		addr_lo_d = addr_lo_q;
		addr_hi_d = addr_hi_q;
		ftype_d = ftype_q;
		vtype_d = vtype_q;
		timer_d = timer_q;
		if (req.wr) begin
			unique case (req.addr)
				`PVM_OFS_ADDR_LO: begin
					addr_lo_d = req.wdata[31:0];
					if (req.wide) begin
						addr_hi_d = req.wdata[47:32];
					end
				end
				`PVM_OFS_ADDR_HI: addr_hi_d = req.wdata[15:0];
				`PVM_OFS_FTYPE: ftype_d = req.wdata[15:0];
				`PVM_OFS_VTYPE: vtype_d = req.wdata[15:0];
				`PVM_OFS_TIMER: timer_d = req.wdata[15:0];
				default: ;
			endcase
		end
		reg_rdata_d = 64'h0;
		if (req.rd) begin
			unique case (req.addr)
				`PVM_OFS_ADDR_LO: begin
					reg_rdata_d[31:0] = addr_lo_q;
					if (req.wide) begin
						reg_rdata_d[63:32] = pad16(addr_hi_q);
					end
				end
				`PVM_OFS_ADDR_HI: reg_rdata_d[31:0] = pad16(addr_hi_q);
				`PVM_OFS_FTYPE: reg_rdata_d[31:0] = pad16(ftype_q);
				`PVM_OFS_VTYPE: reg_rdata_d[31:0] = pad16(vtype_q);
				`PVM_OFS_TIMER: reg_rdata_d[31:0] = pad16(timer_q);
				default: ;
			endcase
		end
	end

	// contents are meaningless until software programs them; zero is
	// only chosen so that nothing reads unknown
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			addr_lo_q <= `PVM_RST_LOW;
			addr_hi_q <= `PVM_RST_WORD;
			ftype_q <= `PVM_RST_WORD;
			vtype_q <= `PVM_RST_WORD;
			timer_q <= `PVM_RST_WORD;
			reg_rdata_q <= 64'h0;
			reg_rvalid_q <= 1'b0;
		end else begin
			addr_lo_q <= addr_lo_d;
			addr_hi_q <= addr_hi_d;
			ftype_q <= ftype_d;
			vtype_q <= vtype_d;
			timer_q <= timer_d;
			reg_rdata_q <= reg_rdata_d;
			reg_rvalid_q <= req.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive matching
	logic [3:0] rx_idx_q, rx_idx_d, rx_cur;
	logic rx_check_q, rx_check_d;
	logic [2:0] m_en, m_start, m_hit;
	logic [7:0] m_exp [3];

	// index of the byte now on rx; a start byte is always index 0
	assign rx_cur = rx.sof ? 4'h0 : rx_idx_q;

	always_comb begin
		rx_idx_d = rx_idx_q;
		if (rx.valid && rx_cur != `PVM_IDX_RX_DONE) begin
			rx_idx_d = rx_cur + 4'h1;
		end
		rx_check_d = rx.valid && rx_cur == `PVM_IDX_TYPE_LO;
		m_en[0] = rx.valid && rx_cur <= `PVM_IDX_DA_LAST;
		m_start[0] = rx_cur == 4'h0;
		m_exp[0] = addr_byte(pause_addr, rx_cur);
		m_en[1] = rx.valid && (rx_cur == `PVM_IDX_TYPE_HI ||
			rx_cur == `PVM_IDX_TYPE_LO);
		m_start[1] = rx_cur == `PVM_IDX_TYPE_HI;
		m_exp[1] = type_byte(ftype_q, rx_cur[0]);
		m_en[2] = m_en[1];
		m_start[2] = m_start[1];
		m_exp[2] = type_byte(vtype_q, rx_cur[0]);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_idx_q <= `PVM_IDX_RX_DONE;
			rx_check_q <= 1'b0;
		end else begin
			rx_idx_q <= rx_idx_d;
			rx_check_q <= rx_check_d;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_match
		pvm_field_match u_match (
			.sys_clk(sys_clk),
			.rstn(rstn),
			.en(m_en[g]),
			.start(m_start[g]),
			.exp_byte(m_exp[g]),
			.got_byte(rx.data),
			.match_q(m_hit[g])
		);
	end

	// one-cycle verdicts, the cycle after the second type byte
	assign rx_pause_hit = rx_check_q & m_hit[0] & m_hit[1];
	assign rx_vlan_hit = rx_check_q & m_hit[2];

	////////////////////////////////////////////////////////////////////////
	// transmit header bytes: pause frame is da, type, opcode, time; source
	// address is added downstream. registers are not snapshotted, so a
	// write during a frame shows in its later bytes.
	pvm_tx_st_t st_q, st_d;
	logic [3:0] tx_idx_d;
	logic tx_valid_d, tx_fire, tx_last;
	logic [7:0] tx_byte_d;

	function automatic logic [7:0] tx_pick(input pvm_tx_st_t s,
		input logic [3:0] i, input logic [47:0] a, input logic [15:0] f,
		input logic [15:0] v, input logic [15:0] t);
		logic [15:0] op;
		op = `PVM_PAUSE_OPCODE;
		tx_pick = 8'h00;
		if (s == PVM_VLAN) begin
			tx_pick = type_byte(v, i[0]);
		end else if (i <= `PVM_IDX_DA_LAST) begin
			tx_pick = addr_byte(a, i);
		end else if (i <= `PVM_TX_TYPE_LO) begin
			tx_pick = type_byte(f, i[0]);
		end else if (i <= `PVM_TX_OP_LO) begin
			tx_pick = type_byte(op, i[0]);
		end else begin
			tx_pick = type_byte(t, i[0]);
		end
	endfunction

	assign tx_fire = tx_valid_q & tx_ready;
	assign tx_last = (st_q == PVM_PAUSE && tx_idx_q == `PVM_TX_PAUSE_LAST) ||
		(st_q == PVM_VLAN && tx_idx_q == `PVM_TX_VLAN_LAST);
	assign tx_busy = st_q != PVM_IDLE;

	always_comb begin
		st_d = st_q;
		tx_idx_d = tx_idx_q;
		tx_valid_d = tx_valid_q;
		unique case (st_q)
			PVM_IDLE: begin
				tx_idx_d = 4'h0;
				if (tx_pause_start) begin
					st_d = PVM_PAUSE;
					tx_valid_d = 1'b1;
				end else if (tx_vlan_start) begin
					st_d = PVM_VLAN;
					tx_valid_d = 1'b1;
				end
			end
			PVM_PAUSE, PVM_VLAN: begin
				if (tx_fire && tx_last) begin
					st_d = PVM_IDLE;
					tx_idx_d = 4'h0;
					tx_valid_d = 1'b0;
				end else if (tx_fire) begin
					tx_idx_d = tx_idx_q + 4'h1;
				end
			end
			default: begin
				st_d = PVM_IDLE;
				tx_valid_d = 1'b0;
			end
		endcase
		tx_byte_d = tx_valid_d ?
			tx_pick(st_d, tx_idx_d, pause_addr, ftype_q, vtype_q, timer_q) :
			8'h00;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= PVM_IDLE;
			tx_idx_q <= 4'h0;
			tx_valid_q <= 1'b0;
			tx_byte_q <= 8'h00;
		end else begin
			st_q <= st_d;
			tx_idx_q <= tx_idx_d;
			tx_valid_q <= tx_valid_d;
			tx_byte_q <= tx_byte_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ft_hi;
		tx_valid_q && st_q == PVM_PAUSE && tx_idx_q == `PVM_TX_TYPE_HI &&
			tx_ready;
	endsequence
	sequence s_vt_hi;
		tx_valid_q && st_q == PVM_VLAN && tx_idx_q == 4'h0 && tx_ready;
	endsequence

	property p_wide_wr;
		@(posedge sys_clk) disable iff (!rstn)
		req.wr && req.wide && req.addr == `PVM_OFS_ADDR_LO |=>
			addr_lo_q == $past(req.wdata[31:0]) &&
			addr_hi_q == $past(req.wdata[47:32]);
	endproperty
	a_wide_wr: assert property (p_wide_wr)
		else $error("paired address write lost");

	property p_rd_zero;
		@(posedge sys_clk) disable iff (!rstn)
		req.rd && req.addr != `PVM_OFS_ADDR_LO |=>
			reg_rvalid_q && reg_rdata_q[63:16] == 48'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("upper read bits not zero");

	property p_da_first;
		@(posedge sys_clk) disable iff (!rstn)
		tx_valid_q && st_q == PVM_PAUSE && tx_idx_q == 4'h0 |->
			tx_byte_q == addr_lo_q[7:0];
	endproperty
	a_da_first: assert property (p_da_first)
		else $error("pause destination first byte wrong");

	property p_ft_order;
		@(posedge sys_clk) disable iff (!rstn)
		s_ft_hi |-> tx_byte_q == ftype_q[15:8] ##1
			tx_idx_q == `PVM_TX_TYPE_LO && tx_byte_q == ftype_q[7:0];
	endproperty
	a_ft_order: assert property (p_ft_order)
		else $error("pause type byte order wrong");

	property p_vt_order;
		@(posedge sys_clk) disable iff (!rstn)
		s_vt_hi |-> tx_byte_q == vtype_q[15:8] ##1
			tx_idx_q == 4'h1 && tx_byte_q == vtype_q[7:0];
	endproperty
	a_vt_order: assert property (p_vt_order)
		else $error("vlan type byte order wrong");

	property p_timer;
		@(posedge sys_clk) disable iff (!rstn)
		tx_valid_q && st_q == PVM_PAUSE && tx_idx_q == `PVM_TX_TIME_HI |->
			tx_byte_q == timer_q[15:8];
	endproperty
	a_timer: assert property (p_timer)
		else $error("pause time byte wrong");

	property p_rx_verdict;
		@(posedge sys_clk) disable iff (!rstn)
		rx.valid && rx_cur == `PVM_IDX_TYPE_LO &&
			rx.data != ftype_q[7:0] |=> !rx_pause_hit;
	endproperty
	a_rx_verdict: assert property (p_rx_verdict)
		else $error("pause hit with wrong type");

	property p_hit_pulse;
		@(posedge sys_clk) disable iff (!rstn)
		rx_pause_hit |=> !rx_pause_hit;
	endproperty
	a_hit_pulse: assert property (p_hit_pulse)
		else $error("pause hit longer than one cycle");

	// eight accepts in a row from the first pause byte
	sequence s_pause_burst;
		($rose(st_q == PVM_PAUSE) && tx_ready) ##1 tx_ready [*7];
	endsequence

	property p_pause_len;
		@(posedge sys_clk) disable iff (!rstn)
		s_pause_burst |-> tx_idx_q == 4'h7;
	endproperty
	a_pause_len: assert property (p_pause_len)
		else $error("pause header not advancing");
endmodule

//--- tb/pvm_station.sv
// remote station model: sends frame headers, sinks transmitted bytes
`timescale 1ns/100ps
module pvm_station
	import pvm_pkg::*;
(
	input wire logic sys_clk,
	output pvm_byte_t rx,
	output logic tx_ready,
	input wire logic tx_valid_q,
	input wire logic [7:0] tx_byte_q
);
	logic [7:0] got[$];
	integer seed = 50787;
	// set by the bench to drain a header with no stalls
	logic hold_rdy = 1'b0;
	initial begin
		rx = '0;
		tx_ready = 1'b0;
	end
	// random stalls so the sender has to hold some bytes
	always @(posedge sys_clk) begin
		if (tx_valid_q && tx_ready) begin
			got.push_back(tx_byte_q);
		end
		tx_ready <= 1'($random(seed)) | hold_rdy;
	end
	// da byte k goes out k-th; filler bytes are not part of any match
	task automatic send(input logic [47:0] da, input logic [15:0] ty);
		integer k;
		for (k = 0; k < 14; k++) begin
			@(posedge sys_clk);
			if (k == 7 && seed[0]) begin
				rx <= '0;
				@(posedge sys_clk);
			end
			rx <= {1'b1, k == 0, k < 6 ? da[8*k+:8] :
				k == 12 ? ty[15:8] : k == 13 ? ty[7:0] : 8'hA5};
		end
		@(posedge sys_clk);
		rx <= '0;
	endtask
endmodule

//--- tb/pvm_top_bench.sv
// self-checking bench for the pause and vlan match block
`timescale 1ns/100ps
`include "pvm_cfg.svh"
module pvm_top_bench
	import pvm_pkg::*;
;
	logic sys_clk, rstn, tx_pause_start, tx_vlan_start, tx_ready;
	logic reg_rvalid_q, rx_pause_hit, rx_vlan_hit, tx_valid_q, tx_busy;
	logic [63:0] reg_rdata_q, rd, d;
	logic [7:0] tx_byte_q;
	logic [3:0] tx_idx_q;
	logic [31:0] lo, hi, ft, vt, tm, v;
	pvm_req_t req;
	pvm_byte_t rx;
	integer err_count = 0, n_compared = 0, seed = 50787, i, n;
	logic [11:0] ofs[6] = '{`PVM_OFS_ADDR_LO, `PVM_OFS_ADDR_HI,
		`PVM_OFS_FTYPE, `PVM_OFS_VTYPE, `PVM_OFS_TIMER, 12'h034};
	pvm_top uut (.sys_clk(sys_clk), .rstn(rstn), .req(req),
		.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .rx(rx),
		.rx_pause_hit(rx_pause_hit), .rx_vlan_hit(rx_vlan_hit),
		.tx_pause_start(tx_pause_start), .tx_vlan_start(tx_vlan_start),
		.tx_ready(tx_ready), .tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q),
		.tx_idx_q(tx_idx_q), .tx_busy(tx_busy));
	pvm_station stn (.sys_clk(sys_clk), .rx(rx), .tx_ready(tx_ready),
		.tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_flag(input logic g, input logic e);
		chk_val({63'h0, g}, {63'h0, e});
	endtask
	task automatic acc(input logic w, r, wd, input logic [11:0] a,
		input logic [63:0] dd);
		@(posedge sys_clk);
		req <= {w, r, wd, a, dd};
		@(posedge sys_clk);
		req <= '0;
		#1 rd = reg_rdata_q;
		if (r) chk_flag(reg_rvalid_q, 1'b1);
	endtask
	task automatic prog;
		acc(1, 0, 0, ofs[0], {32'h0, lo});
		acc(1, 0, 0, ofs[1], {32'h0, hi});
		acc(1, 0, 0, ofs[2], {32'h0, ft});
		acc(1, 0, 0, ofs[3], {32'h0, vt});
		acc(1, 0, 0, ofs[4], {32'h0, tm});
	endtask
	// masked readback expected after writing v at slot k
	function automatic logic [63:0] exp_rd(input integer k);
		exp_rd = k == 0 ? {32'h0, v} : k == 5 ? 64'h0 : {48'h0, v[15:0]};
	endfunction
	function automatic logic [7:0] exp_tx(input integer k);
		logic [47:0] a;
		logic [47:0] t;
		a = {hi[15:0], lo};
		t = {ft[15:0], `PVM_PAUSE_OPCODE, tm[15:0]};
		exp_tx = k < 6 ? a[8*k+:8] : t[8*(11-k)+:8];
	endfunction
	task automatic rx_chk(input logic [47:0] da, input logic [15:0] ty,
		input logic ep, input logic ev);
		stn.send(da, ty);
		#1 chk_flag(rx_pause_hit, ep);
		chk_flag(rx_vlan_hit, ev);
		@(posedge sys_clk);
		#1 chk_flag(rx_pause_hit, 1'b0);
	endtask
	// a vlan start during a pause header must be dropped
	task automatic tx_run(input logic p);
		n = p ? 12 : 2;
		stn.got.delete();
		@(posedge sys_clk);
		tx_pause_start <= p;
		tx_vlan_start <= ~p;
		@(posedge sys_clk);
		tx_pause_start <= 1'b0;
		tx_vlan_start <= p;
		@(posedge sys_clk);
		tx_vlan_start <= 1'b0;
		#1 chk_flag(tx_busy, 1'b1);
		for (i = 0; i < 300 && tx_busy === 1'b1; i++) begin
			// index of the byte on offer equals bytes taken so far
			chk_val(tx_idx_q, stn.got.size());
			@(posedge sys_clk);
			#1;
		end
		chk_flag(tx_valid_q, 1'b0);
		chk_val(stn.got.size(), n);
		for (i = 0; i < n; i++) begin
			v[7:0] = p ? exp_tx(i) : vt[15-8*i-:8];
			chk_val(stn.got[i], v[7:0]);
		end
		$display("tx test done");
	endtask
	initial begin
		#1000000;
		err_count++;
		finish_test();
	end
	initial begin
		rstn = 1'b0;
		req = '0;
		tx_pause_start = 1'b0;
		tx_vlan_start = 1'b0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		for (n = 0; n < 4; n++) begin
			for (i = 0; i < 6; i++) begin
				v = $random(seed);
				acc(1, 0, 0, ofs[i], {$random(seed), v});
				acc(0, 1, 0, ofs[i], 64'h0);
				chk_val(rd, exp_rd(i));
			end
		end
		d = {$random(seed), $random(seed)};
		acc(1, 0, 1, ofs[0], d);
		acc(0, 1, 1, ofs[0], 64'h0);
		chk_val(rd, {16'h0, d[47:0]});
		acc(0, 1, 0, ofs[1], 64'h0);
		chk_val(rd, {48'h0, d[47:32]});
		$display("register test done");
		lo = 32'h00C2_8001;
		hi = 32'h0000_0100;
		ft = 32'h0000_8808;
		vt = 32'h0000_8100;
		tm = $random(seed) & 32'hFFFF;
		prog();
		rx_chk(48'h0100_00C2_8001, 16'h8808, 1'b1, 1'b0);
		rx_chk(48'h0000_00C2_8001, 16'h8808, 1'b0, 1'b0);
		rx_chk(48'h0100_00C2_8001, 16'h8100, 1'b0, 1'b1);
		$display("rx test done");
		tx_run(1'b1);
		tx_run(1'b0);
		tm = 32'h0;
		prog();
		// no stalls here, so the unbroken header burst is exercised
		stn.hold_rdy = 1'b1;
		tx_run(1'b1);
		stn.hold_rdy = 1'b0;
		repeat (3) begin
			lo = $random(seed);
			hi = $random(seed) & 32'hFFFF;
			ft = $random(seed) & 32'hFFFF;
			vt = $random(seed) & 32'hFFFF;
			tm = $random(seed) & 32'hFFFF;
			prog();
			rx_chk({hi[15:0], lo}, ft[15:0], 1'b1, ft == vt);
			tx_run(1'b1);
			tx_run(1'b0);
		end
		finish_test();
	end
endmodule
